// ### outsel_params.svh
// Constants for the output select and status register bank
`ifndef OUTSEL_PARAMS_SVH
`define OUTSEL_PARAMS_SVH

`define ADDR_W            6
`define DATA_W            24
`define ADDR_CHAN_COUNT   6'h0c
`define ADDR_PIN_SEL      6'h0f
`define ADDR_RSV_A        6'h10
`define ADDR_RSV_B        6'h11
`define ADDR_OUT_STATUS   6'h12
`define ADDR_SELF_TEST    6'h13

`define CHAN_W            14
`define CHAN_RESET        14'h0000
`define CHAN_MIN_ON       14'h0002

`define CTRL_W            10
`define CTRL_RESET        10'h001
`define SEL_LSB           0
`define SEL_MSB           4
`define TEST_BIT          5
`define NO_AUTOMUX_BIT    6
`define KEEP_DRIVER_BIT   7
`define PFET_OFF_BIT      8
`define NFET_OFF_BIT      9

`define RSV_A_W           9
`define RSV_B_W           19
`define STAT_W            2
`define STAT_LEVEL_BIT    0
`define STAT_LOCK_BIT     1
`define SIG_W             16
`define TEST_W            17
`define TEST_BUSY_BIT     16

`define SRC_N             32
`define SEL_TEST_DATA     5'h00
`define SEL_RESERVED      5'h07
`define SEL_UNUSED_LO     5'h1a
`define SEL_UNUSED_HI     5'h1d

`endif

// ### outsel_pkg.sv
// Types shared by the output select and status register bank
package outsel_pkg;
    typedef logic [4:0]  src_sel_t;
    typedef logic [13:0] chan_count_t;
    typedef logic [23:0] reg_word_t;
endpackage

// ### pin_route_if.sv
// Signals between the register bank and the output source selector
`timescale 1ns/10ps
interface pin_route_if;
    import outsel_pkg::*;
    src_sel_t    sel;
    logic        test_bit;
    logic [31:0] sources;
    logic        level;
    modport ctrl (output sel, output test_bit, output sources, input level);
    modport mux  (input sel, input test_bit, input sources, output level);
endinterface

// ### pin_source_mux.sv
// Output source selector for the serial data-out pin
`timescale 1ns/10ps
`include "outsel_params.svh"
module pin_source_mux
    import outsel_pkg::*;
(
    input  wire logic  clk_in,
    input  wire logic  rst_in,
    pin_route_if.mux   route
);
    wire   is_test;
    wire   is_dead;
    assign is_test = (route.sel == `SEL_TEST_DATA);
    // Reserved and unused codes drive a quiet low instead of floating
    assign is_dead = (route.sel == `SEL_RESERVED) ||
                     ((route.sel >= `SEL_UNUSED_LO) && (route.sel <= `SEL_UNUSED_HI));
    // Codes 1..31 other than 7 and 26..29 pick their source bit by index
    assign route.level = is_test ? route.test_bit :
                         is_dead ? 1'b0 : route.sources[route.sel];

    ////////////////////////////////////////////////////////////////////////////
    a_test_route: assert property (@(posedge clk_in) disable iff (rst_in)
        (route.sel == `SEL_TEST_DATA) |-> (route.level == route.test_bit))
        else $error("test data not routed on code 0");
    a_unused_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
        (route.sel >= `SEL_UNUSED_LO && route.sel <= `SEL_UNUSED_HI) |-> !route.level)
        else $error("unused code drives a level");
    a_lock_route: assert property (@(posedge clk_in) disable iff (rst_in)
        (route.sel == 5'h01) |-> (route.level == route.sources[1]))
        else $error("code 1 not lock detect");
endmodule

// ### output_select_status_regs.sv
// Output select, channel count and status registers of the synthesizer
// Functional notes
// - 14-bit channel count; 0 and 1 disable exact frequency, 2..3FFFh enable it.
// - Channel count acts only in modulator mode B; host writes zero otherwise.
// - 5-bit selector, reset 1, picks the signal driven on data-out.
// - Code 0 drives the test data bit 5 onto data-out.
// - Codes 1..3 route lock detect, its trigger and its window output.
// - Code 4 ring oscillator, 5 and 6 slip-prevention pulls, 7 reserved.
// - Codes 8..11 route reference buffer, reference divider, VCO divider, modulator clock.
// - Codes 12..15 auxiliary clock and serial lines; 16..19 detector and modulator clocks.
// - Codes 20..25 route autostrobes, serial latch enable, sync reset, seed load.
// - Codes 26..29 unused; 30 serial buffer enable; 31 soft reset.
// - Bit 6 set stops lock detect automux onto data-out.
// - Bit 7 set keeps the serial interface from disabling the driver.
// - Read-only status: bit 0 output level, bit 1 lock detect, reset 0.
// - Read-only self-test: 16-bit signature and busy in bit 16, reset 0.
// - Reserved registers 10h and 11h read-only, 9 and 19 bits, read zero.
`timescale 1ns/10ps
`include "outsel_params.svh"
module output_select_status_regs
    import outsel_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    input  wire logic                reg_wr_in,
    input  wire logic [5:0]          reg_addr_in,
    input  wire logic [23:0]         reg_wdata_in,
    output logic      [23:0]         reg_rdata_out,
    input  wire logic                mod_mode_b_in,
    output logic      [13:0]         chan_count_out,
    output logic                     exact_freq_en_out,
    input  wire logic [31:0]         src_signals_in,
    input  wire logic                lock_detect_in,
    input  wire logic                gpo_enable_in,
    input  wire logic                spi_read_active_in,
    input  wire logic                spi_read_data_in,
    input  wire logic                spi_drv_disable_in,
    input  wire logic [15:0]         bist_signature_in,
    input  wire logic                bist_busy_in,
    input  wire logic                sdo_in,
    output logic                     sdo_out,
    output logic                     sdo_oe_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    chan_count_t                chan_ff;
    logic [`CTRL_W-1:0]         ctrl_ff;
    logic [`RSV_A_W-1:0]        rsv_a_ff;
    logic [`RSV_B_W-1:0]        rsv_b_ff;
    logic [`STAT_W-1:0]         stat_ff;
    logic [`TEST_W-1:0]         test_ff;
    reg_word_t                  rdata_ff;
    logic                       sdo_ff;
    logic                       oe_ff;

    chan_count_t                nxt_chan;
    logic [`CTRL_W-1:0]         nxt_ctrl;
    logic [`STAT_W-1:0]         nxt_stat;
    logic [`TEST_W-1:0]         nxt_test;
    reg_word_t                  nxt_rdata;
    logic                       nxt_sdo;
    logic                       nxt_oe;

    ////////////////////////////////////////////////////////////////////////////
    // Write decode; read-only addresses simply ignore writes
    wire                        wr_chan;
    wire                        wr_ctrl;
    assign wr_chan  = reg_wr_in && (reg_addr_in == `ADDR_CHAN_COUNT);
    assign wr_ctrl  = reg_wr_in && (reg_addr_in == `ADDR_PIN_SEL);
    assign nxt_chan = wr_chan ? reg_wdata_in[`CHAN_W-1:0] : chan_ff;
    assign nxt_ctrl = wr_ctrl ? reg_wdata_in[`CTRL_W-1:0] : ctrl_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Control fields
    wire                        test_bit;
    wire                        no_automux;
    wire                        keep_driver;
    wire                        pfet_off;
    wire                        nfet_off;
    assign test_bit    = ctrl_ff[`TEST_BIT];
    assign no_automux  = ctrl_ff[`NO_AUTOMUX_BIT];
    assign keep_driver = ctrl_ff[`KEEP_DRIVER_BIT];
    assign pfet_off    = ctrl_ff[`PFET_OFF_BIT];
    assign nfet_off    = ctrl_ff[`NFET_OFF_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Exact-frequency enable; the enable is gated off outside mode B, the count output is not masked
    wire                        chan_valid;
    assign chan_valid        = (chan_ff >= `CHAN_MIN_ON);
    assign exact_freq_en_out = chan_valid && mod_mode_b_in;
    assign chan_count_out    = chan_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Source selection
    pin_route_if route ();
    assign route.sel      = ctrl_ff[`SEL_MSB:`SEL_LSB];
    assign route.test_bit = test_bit;
    assign route.sources  = src_signals_in;

    pin_source_mux u_mux (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .route  (route.mux)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Data-out pin: readback first, then general output, then lock automux
    wire                        idle_level;
    wire                        idle_drive;
    wire                        want_level;
    wire                        want_drive;
    assign idle_level = gpo_enable_in ? route.level : lock_detect_in;
    assign idle_drive = gpo_enable_in || !no_automux;
    assign want_level = spi_read_active_in ? spi_read_data_in : idle_level;
    // The serial interface may cut the driver unless software pins it on
    assign want_drive = spi_read_active_in ||
                        (idle_drive && (keep_driver || !spi_drv_disable_in));
    // A disabled transistor half cannot drive its level; the other half still can
    assign nxt_oe  = want_drive && (want_level ? !pfet_off : !nfet_off);
    assign nxt_sdo = want_level;

    ////////////////////////////////////////////////////////////////////////////
    // Status capture
    assign nxt_stat = {lock_detect_in, route.level};
    assign nxt_test = {bist_busy_in, bist_signature_in};

    ////////////////////////////////////////////////////////////////////////////
    // Read decode, one cycle of latency
    wire                        rd_chan;
    wire                        rd_ctrl;
    wire                        rd_rsv_a;
    wire                        rd_rsv_b;
    wire                        rd_stat;
    wire                        rd_test;
    assign rd_chan  = (reg_addr_in == `ADDR_CHAN_COUNT);
    assign rd_ctrl  = (reg_addr_in == `ADDR_PIN_SEL);
    assign rd_rsv_a = (reg_addr_in == `ADDR_RSV_A);
    assign rd_rsv_b = (reg_addr_in == `ADDR_RSV_B);
    assign rd_stat  = (reg_addr_in == `ADDR_OUT_STATUS);
    assign rd_test  = (reg_addr_in == `ADDR_SELF_TEST);
    assign nxt_rdata =
        rd_chan  ? {{(`DATA_W-`CHAN_W){1'b0}}, chan_ff}  :
        rd_ctrl  ? {{(`DATA_W-`CTRL_W){1'b0}}, ctrl_ff}  :
        rd_rsv_a ? {{(`DATA_W-`RSV_A_W){1'b0}}, rsv_a_ff} :
        rd_rsv_b ? {{(`DATA_W-`RSV_B_W){1'b0}}, rsv_b_ff} :
        rd_stat  ? {{(`DATA_W-`STAT_W){1'b0}}, stat_ff}  :
        rd_test  ? {{(`DATA_W-`TEST_W){1'b0}}, test_ff}  :
        24'h000000;

    ////////////////////////////////////////////////////////////////////////////
    // Flip-flops
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            chan_ff <= `CHAN_RESET;
            ctrl_ff <= `CTRL_RESET;
        end else begin
            chan_ff <= nxt_chan;
            ctrl_ff <= nxt_ctrl;
        end
    end

    // Reserved storage has no write path and stays at its reset value
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rsv_a_ff <= 9'h000;
            rsv_b_ff <= 19'h00000;
        end else begin
            rsv_a_ff <= rsv_a_ff;
            rsv_b_ff <= rsv_b_ff;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stat_ff <= 2'h0;
            test_ff <= 17'h00000;
        end else begin
            stat_ff <= nxt_stat;
            test_ff <= nxt_test;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_ff <= 24'h000000;
            sdo_ff   <= 1'b0;
            oe_ff    <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            sdo_ff   <= nxt_sdo;
            oe_ff    <= nxt_oe;
        end
    end

    assign reg_rdata_out = rdata_ff;
    assign sdo_out       = sdo_ff;
    assign sdo_oe_out    = oe_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_reset_select: assert property (@(posedge clk_in)
        $fell(rst_in) |-> (route.sel == 5'h01))
        else $error("selector not 1 after reset");
    a_sel_write: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_ctrl |=> (route.sel == $past(reg_wdata_in[4:0])))
        else $error("selector write lost");
    a_exact_gate: assert property (@(posedge clk_in) disable iff (rst_in)
        (!mod_mode_b_in || chan_ff < 14'h0002) |-> !exact_freq_en_out)
        else $error("exact frequency on outside mode B or count below 2");
    a_exact_on: assert property (@(posedge clk_in) disable iff (rst_in)
        (wr_chan && reg_wdata_in[13:0] >= 14'h0002) ##1 mod_mode_b_in |-> exact_freq_en_out)
        else $error("exact frequency not enabled");
    a_ro_ignore: assert property (@(posedge clk_in) disable iff (rst_in)
        (reg_wr_in && reg_addr_in >= 6'h10 && reg_addr_in <= 6'h13) |=> $stable(ctrl_ff) && $stable(chan_ff))
        else $error("read-only write changed a register");
    a_rsv_zero: assert property (@(posedge clk_in) disable iff (rst_in)
        (reg_addr_in == 6'h10 || reg_addr_in == 6'h11) |=> (reg_rdata_out == 24'h000000))
        else $error("reserved register reads nonzero");
    a_status_read: assert property (@(posedge clk_in) disable iff (rst_in)
        (reg_addr_in == 6'h12) ##1 (reg_addr_in == 6'h12)
            |-> (reg_rdata_out == {22'h0, $past(lock_detect_in, 2), $past(route.level, 2)}))
        else $error("status readback wrong");
    a_bist_read: assert property (@(posedge clk_in) disable iff (rst_in)
        (reg_addr_in == 6'h13) ##1 (reg_addr_in == 6'h13)
            |-> (reg_rdata_out[16] == $past(bist_busy_in, 2)) && (reg_rdata_out[23:17] == 7'h00))
        else $error("self-test readback wrong");
    a_driver_keep: assert property (@(posedge clk_in) disable iff (rst_in)
        (keep_driver && gpo_enable_in && !pfet_off && !nfet_off) |=> sdo_oe_out)
        else $error("driver dropped while kept on");
    a_automux_off: assert property (@(posedge clk_in) disable iff (rst_in)
        (no_automux && !gpo_enable_in && !spi_read_active_in) |=> !sdo_oe_out)
        else $error("lock detect muxed while inhibited");
    a_pfet_half: assert property (@(posedge clk_in) disable iff (rst_in)
        pfet_off && $stable(ctrl_ff) |=> !(sdo_oe_out && sdo_out))
        else $error("pull-up half drives while disabled");
    a_gpo_path: assert property (@(posedge clk_in) disable iff (rst_in)
        (gpo_enable_in && !spi_read_active_in) |=> (sdo_out == $past(route.level)))
        else $error("selected source not on data-out");

    c_test_data: cover property (@(posedge clk_in) disable iff (rst_in)
        wr_ctrl && reg_wdata_in[5:0] == 6'h20 ##2 gpo_enable_in && sdo_out);
    c_exact_on: cover property (@(posedge clk_in) disable iff (rst_in)
        exact_freq_en_out);
    c_readback: cover property (@(posedge clk_in) disable iff (rst_in)
        spi_read_active_in && spi_drv_disable_in ##1 sdo_oe_out);
    c_automux: cover property (@(posedge clk_in) disable iff (rst_in)
        !gpo_enable_in && !no_automux && lock_detect_in ##1 sdo_out);

endmodule

// ### host_model.sv
// Host serial controller model driving the register port
`timescale 1ns/10ps
module host_model (
    input  wire logic        clk_in,
    output logic             reg_wr_out,
    output logic [5:0]       reg_addr_out,
    output logic [23:0]      reg_wdata_out,
    input  wire logic [23:0] reg_rdata_in
);
    initial begin
        reg_wr_out = 1'b0;
        reg_addr_out = 6'h00;
        reg_wdata_out = 24'h000000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Callers pass whole-number ratios only; t_chan_count leaves the count at 3FFFh outside mode B, then writes zero
    task automatic wr_reg(input logic [5:0] a, input logic [23:0] d);
        @(posedge clk_in);
        #1;
        reg_wr_out = 1'b1;
        reg_addr_out = a;
        reg_wdata_out = d;
        @(posedge clk_in);
        #1;
        reg_wr_out = 1'b0;
        // Released data lines must not look like a held value
        reg_wdata_out = ~d;
    endtask

    task automatic rd_reg(input logic [5:0] a, output logic [23:0] d);
        @(posedge clk_in);
        #1;
        reg_addr_out = a;
        @(posedge clk_in);
        #1;
        d = reg_rdata_in;
    endtask
endmodule

// ### tb.sv
// Self-checking bench for the output select and status register bank
`timescale 1ns/10ps
module tb;
    logic        clk_in, rst_in, reg_wr, mode_b, lock, gpo_en, rd_act, rd_dat, drv_dis, busy;
    logic [5:0]  addr;
    logic [23:0] wdata, rdata, got;
    logic [31:0] src;
    logic [15:0] sig;
    logic [13:0] chan;
    logic        ef_en, sdo, sdo_oe;
    int          failures, tests_run, cyc;

    output_select_status_regs uut (.clk_in(clk_in), .rst_in(rst_in), .reg_wr_in(reg_wr),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .mod_mode_b_in(mode_b),
        .chan_count_out(chan), .exact_freq_en_out(ef_en), .src_signals_in(src),
        .lock_detect_in(lock), .gpo_enable_in(gpo_en), .spi_read_active_in(rd_act),
        .spi_read_data_in(rd_dat), .spi_drv_disable_in(drv_dis), .bist_signature_in(sig),
        .bist_busy_in(busy), .sdo_in(1'b0), .sdo_out(sdo), .sdo_oe_out(sdo_oe));
    host_model host (.clk_in(clk_in), .reg_wr_out(reg_wr), .reg_addr_out(addr),
        .reg_wdata_out(wdata), .reg_rdata_in(rdata));

    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (failures == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [23:0] g, input logic [23:0] e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: word %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_bit(input logic g, input logic e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: bit %b expected %b", $time, g, e);
        end
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [23:0] e);
        host.rd_reg(a, got);
        chk_word(got, e);
    endtask

    // One registered cycle for the pin logic to follow its inputs
    task automatic step;
        @(posedge clk_in);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values;
        rd_chk(6'h0c, 24'h000000);
        rd_chk(6'h0f, 24'h000001);
        rd_chk(6'h10, 24'h000000);
        rd_chk(6'h11, 24'h000000);
        rd_chk(6'h12, 24'h000000);
        rd_chk(6'h13, 24'h000000);
        rd_chk(6'h20, 24'h000000);
    endtask

    task automatic t_chan_count;
        logic [13:0] vals [4] = '{14'h0000, 14'h0001, 14'h0002, 14'h3fff};
        mode_b = 1'b1;
        foreach (vals[i]) begin
            host.wr_reg(6'h0c, {10'h3ff, vals[i]});
            chk_word({10'h000, chan}, {10'h000, vals[i]});
            chk_bit(ef_en, vals[i] >= 14'h0002);
            rd_chk(6'h0c, {10'h000, vals[i]});
        end
        mode_b = 1'b0;
        #1;
        chk_bit(ef_en, 1'b0);
        host.wr_reg(6'h0c, 24'h000000);
    endtask

    task automatic t_readonly;
        for (int a = 'h10; a <= 'h13; a++) begin
            host.wr_reg(a[5:0], 24'hffffff);
            rd_chk(a[5:0], 24'h000000);
        end
    endtask

    task automatic t_select_sweep;
        logic e;
        gpo_en = 1'b1;
        for (int k = 0; k < 32; k++) begin
            e = !(k == 7 || (k >= 26 && k <= 29));
            host.wr_reg(6'h0f, (k == 0) ? 24'h000020 : 24'(k));
            src = 32'h1 << k;
            step();
            chk_bit(sdo, e);
            chk_bit(sdo_oe, 1'b1);
            host.wr_reg(6'h0f, 24'(k));
            src = ~(32'h1 << k);
            step();
            chk_bit(sdo, 1'b0);
        end
    endtask

    task automatic t_driver_ctrl;
        // Last entry: pull-up half off while driving low, so the pull-down half must still drive
        logic [23:0] ctl [7] = '{24'h000020, 24'h000000, 24'h0000a0, 24'h000060,
                                 24'h000120, 24'h000200, 24'h000100};
        logic        lv [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        logic        oe [7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
        logic        ge [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
        rd_act = 1'b1;
        rd_dat = 1'b1;
        drv_dis = 1'b1;
        step();
        chk_bit(sdo, 1'b1);
        chk_bit(sdo_oe, 1'b1);
        rd_act = 1'b0;
        lock = 1'b0;
        foreach (ctl[i]) begin
            drv_dis = (i < 3);
            gpo_en = ge[i];
            host.wr_reg(6'h0f, ctl[i]);
            step();
            chk_bit(sdo, lv[i]);
            chk_bit(sdo_oe, oe[i]);
        end
        drv_dis = 1'b0;
        gpo_en = 1'b0;
        lock = 1'b1;
        host.wr_reg(6'h0f, 24'h000000);
        step();
        chk_bit(sdo, 1'b1);
        chk_bit(sdo_oe, 1'b1);
    endtask

    task automatic t_status;
        host.wr_reg(6'h0f, 24'h000020);
        sig = 16'ha5c3;
        busy = 1'b1;
        rd_chk(6'h12, 24'h000003);
        rd_chk(6'h13, 24'h01a5c3);
        rst_in = 1'b1;
        step();
        rst_in = 1'b0;
        sig = 16'h0000;
        busy = 1'b0;
        lock = 1'b0;
        src = 32'h0;
        rd_chk(6'h0f, 24'h000001);
        rd_chk(6'h12, 24'h000000);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    // Whole run needs well under a thousand cycles; a hang ends here
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            close_out();
        end
    end

    initial begin
        {rst_in, mode_b, lock, gpo_en, rd_act, rd_dat, drv_dis, busy} = 8'h80;
        src = 32'h0;
        sig = 16'h0000;
        repeat (10) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        t_reset_values();
        t_chan_count();
        t_readonly();
        t_select_sweep();
        t_driver_ctrl();
        t_status();
        close_out();
    end
endmodule
